// file: core/hts_cfg.svh
`ifndef HTS_CFG_SVH
`define HTS_CFG_SVH

// bus address and register pointers
`define I2C_SLAVE_ADDR 7'h40
`define PTR_TEMP       8'h00
`define PTR_HUM        8'h01
`define PTR_CFG        8'h02
`define PTR_SER_HI     8'hFB
`define PTR_SER_MID    8'hFC
`define PTR_SER_LO     8'hFD
`define PTR_MFG_ID     8'hFE
`define PTR_DEV_ID     8'hFF

// configuration register layout
`define CFG_RESET      16'h1000
`define CFG_WR_MASK    16'h3700
`define CFG_RST_BIT    15
`define CFG_HEATER_ENABLE_BIT   13
`define CFG_MODE_BIT   12
`define CFG_LOW_SUPPLY_FLAG_BIT   11
`define CFG_TEMP_RESOLUTION_SEL_BIT   10
`define CFG_HUMIDITY_RESOLUTION_SEL_HI    9
`define CFG_HUMIDITY_RESOLUTION_SEL_LO    8
`define HUMIDITY_RESOLUTION_SEL_14        2'h0
`define HUMIDITY_RESOLUTION_SEL_11        2'h1
`define HUMIDITY_RESOLUTION_SEL_8         2'h2

// timing, in microseconds, and clock rate
`define CLK_MHZ        100
`define T_START_US     15000
`define T_TEMP14_US    6350
`define T_TEMP11_US    3650
`define T_HUM14_US     6500
`define T_HUM11_US     3850
`define T_HUM8_US      2500

`endif

// file: core/hts_pkg.sv
package hts_pkg;

  // serial engine states, gray along idle, receive, ack, transmit, master ack
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_MACK = 3'h6
  } i2c_state_t;

  // measurement sequencer states
  typedef enum logic [1:0] {
    SEQ_SLEEP  = 2'h0,
    SEQ_CONV_T = 2'h1,
    SEQ_CONV_H = 2'h3
  } seq_state_t;

endpackage

// file: core/sync2.sv
`timescale 1ns/1ns
module sync2 #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  // first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q       <= RST_VAL;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

// file: core/hts_measure_ctrl.sv
`timescale 1ns/1ns
`include "hts_cfg.svh"
// Behaviour
// RL1: answer only as bus slave at seven-bit address 1000000, after address plus direction
// RL2: first byte after a write address is loaded into the register pointer
// RL3: reads return the register the pointer selects; reads never move the pointer
// RL4: master changes register by pointer-only write, then start and read address
// RL5: registers go upper byte first, each byte most significant bit first
// RL6: data bytes written to read-only registers get a not-acknowledge
// RL7: pointer byte naming an unused register gets a not-acknowledge
// RL8: address byte with a foreign slave address gets a not-acknowledge
// RL9: ready for measurements within 15 ms of power; no trigger accepted before
// RL10: during power-up window serve only serial and identification reads
// RL11: start in sleep, measure on trigger, return to sleep when done
// RL12: combined mode with pointer 0x00 converts temperature then humidity
// RL13: single mode converts temperature for pointer 0x00, humidity for 0x01
// RL14: temperature resolution bit selects 14-bit when clear, 11-bit when set
// RL15: humidity field selects 14, 11 or 8 bit for 00, 01, 10
// RL16: after combined conversion one read gives temperature then humidity
// RL17: reading a result not yet updated is answered with not-acknowledge
// RL18: reading results during a conversion leaves it running
// RL19: a write addressing a result register during conversion aborts it
// RL20: heater runs only in measurement mode when enabled, off in sleep
// RL21: low-supply flag refreshed after power-on reset and at each trigger
// RL22: register pointer is 0x00 after power-on reset
// RL23: result registers hold 14-bit value on top, two low bits zero
// RL24: writing the software reset bit resets the device; bit self-clears
module hts_measure_ctrl
  import hts_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = `T_START_US * `CLK_MHZ,
  parameter int unsigned TEMP14_CYC  = `T_TEMP14_US * `CLK_MHZ,
  parameter int unsigned TEMP11_CYC  = `T_TEMP11_US * `CLK_MHZ,
  parameter int unsigned HUM14_CYC   = `T_HUM14_US * `CLK_MHZ,
  parameter int unsigned HUM11_CYC   = `T_HUM11_US * `CLK_MHZ,
  parameter int unsigned HUM8_CYC    = `T_HUM8_US * `CLK_MHZ,
  parameter logic [39:0] SERIAL_ID   = 40'h0123456789, // arbitrary value
  parameter logic [15:0] MFG_ID      = 16'hA5A5,       // arbitrary value
  parameter logic [15:0] DEV_ID      = 16'h5A5A        // arbitrary value
) (
  // system
  input  wire logic        clk,
  input  wire logic        rst,
  // serial bus pins, open drain
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // analog front end
  input  wire logic [13:0] temp_code,
  input  wire logic [13:0] hum_code,
  input  wire logic        supply_low,
  output logic             meas_active,
  output logic             conv_temp,
  output logic             conv_hum,
  output logic             heater_on
);

  logic [2:0]  pin_s;
  logic        scl_s;
  logic        sda_s;
  logic        low_s;
  logic        scl_d_ff;
  logic        sda_d_ff;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  i2c_state_t  state_ff;
  logic [2:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [2:0]  byte_no_ff;
  logic        rw_ff;
  logic        ack_ff;
  logic        full_ff;
  logic        mack_ff;
  logic [1:0]  rd_idx_ff;
  logic        nxt_ack;
  logic [7:0]  rx_byte;
  logic        rx_end;
  logic [7:0]  rd_sel;
  logic [15:0] rd_word;
  logic [7:0]  tx_byte;
  logic        rd_ready;
  logic        ptr_wr;
  logic        wr_hi;
  logic        wr_lo;
  logic        soft_rst;
  logic        abort_req;
  logic        trig_pend_ff;
  logic        trig_fire;
  logic [7:0]  ptr_ff;
  logic [15:0] cfg_ff;
  logic [7:0]  cfg_hi_ff;
  logic        startup_ff;
  logic [20:0] start_cnt_ff;
  logic [1:0]  por_ff;
  logic        low_flag_ff;
  seq_state_t  seq_ff;
  logic [20:0] cnt_ff;
  logic [20:0] temp_len;
  logic [20:0] hum_len;
  logic        comb_ff;
  logic        combined;
  logic        rdy_t_ff;
  logic        rdy_h_ff;
  logic [13:0] temp_ff;
  logic [13:0] hum_ff;

  function automatic logic is_serial(input logic [7:0] p);
    is_serial = (p >= `PTR_SER_HI);
  endfunction

  function automatic logic is_known(input logic [7:0] p);
    is_known = (p <= `PTR_CFG) || (p >= `PTR_SER_HI);
  endfunction

  // pins cross into the clock domain; bus idles high
  sync2 #(
    .WIDTH   (3),
    .RST_VAL (3'h6)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({scl_i, sda_i, supply_low}),
    .q   (pin_s)
  );

  assign scl_s = pin_s[2];
  assign sda_s = pin_s[1];
  assign low_s = pin_s[0];

  // previous line levels for edge and condition detection
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign rx_byte   = {shift_ff[6:0], sda_s};
  assign rx_end    = (state_ff == ST_RX) && scl_rise && (bit_cnt_ff == 3'h7);

  // readiness of the selected register for a read
  always_comb begin
    case (ptr_ff)
      `PTR_TEMP: rd_ready = rdy_t_ff & (~comb_ff | rdy_h_ff); // [RL17]
      `PTR_HUM:  rd_ready = rdy_h_ff; // [RL17]
      `PTR_CFG:  rd_ready = 1'b1;
      default:   rd_ready = is_serial(ptr_ff);
    endcase
  end

  // acknowledge decision for the byte that just completed
  always_comb begin
    nxt_ack = 1'b0;
    if (byte_no_ff == 3'h0) begin
      if (rx_byte[7:1] == `I2C_SLAVE_ADDR) begin // [RL1] [RL8]
        if (!rx_byte[0]) begin
          nxt_ack = 1'b1;
        end else begin
          nxt_ack = startup_ff ? is_serial(ptr_ff) : rd_ready; // [RL10] [RL17]
        end
      end
    end else if (byte_no_ff == 3'h1) begin
      nxt_ack = startup_ff ? is_serial(rx_byte) : is_known(rx_byte); // [RL7] [RL10]
    end else begin
      // only the configuration takes data, two bytes at most
      nxt_ack = (ptr_ff == `PTR_CFG) && !startup_ff && (byte_no_ff <= 3'h3); // [RL6]
    end
  end

  assign ptr_wr    = rx_end && (byte_no_ff == 3'h1) && nxt_ack; // [RL2]
  assign wr_hi     = rx_end && (byte_no_ff == 3'h2) && nxt_ack;
  assign wr_lo     = rx_end && (byte_no_ff == 3'h3) && nxt_ack;
  assign soft_rst  = wr_lo && cfg_hi_ff[`CFG_RST_BIT - 8]; // [RL24]
  assign abort_req = ptr_wr && (rx_byte <= `PTR_HUM) && (seq_ff != SEQ_SLEEP); // [RL19]
  assign trig_fire = trig_pend_ff && (start_det || stop_det);
  assign combined  = cfg_ff[`CFG_MODE_BIT] && (ptr_ff == `PTR_TEMP);

  // read data: temperature register continues into humidity
  always_comb begin
    rd_sel = ((ptr_ff == `PTR_TEMP) && rd_idx_ff[1]) ? `PTR_HUM : ptr_ff; // [RL16]
    case (rd_sel)
      `PTR_TEMP:    rd_word = {temp_ff, 2'h0}; // [RL23]
      `PTR_HUM:     rd_word = {hum_ff, 2'h0}; // [RL23]
      `PTR_CFG:     rd_word = {cfg_ff[15:12], low_flag_ff, cfg_ff[10:0]};
      `PTR_SER_HI:  rd_word = SERIAL_ID[39:24];
      `PTR_SER_MID: rd_word = SERIAL_ID[23:8];
      `PTR_SER_LO:  rd_word = {SERIAL_ID[7:0], 8'h00};
      `PTR_MFG_ID:  rd_word = MFG_ID;
      `PTR_DEV_ID:  rd_word = DEV_ID;
      default:      rd_word = 16'h0000;
    endcase
    tx_byte = rd_idx_ff[0] ? rd_word[7:0] : rd_word[15:8]; // [RL5]
  end

  // serial engine; start and stop override any state
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff   <= ST_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_ff   <= 8'h00;
      byte_no_ff <= 3'h0;
      rw_ff      <= 1'b0;
      ack_ff     <= 1'b0;
      full_ff    <= 1'b0;
      mack_ff    <= 1'b0;
      rd_idx_ff  <= 2'h0;
      sda_oe     <= 1'b0;
    end else if (start_det) begin
      state_ff   <= ST_RX;
      bit_cnt_ff <= 3'h0;
      byte_no_ff <= 3'h0;
      full_ff    <= 1'b0;
      rd_idx_ff  <= 2'h0;
      sda_oe     <= 1'b0;
    end else if (stop_det) begin
      state_ff <= ST_IDLE;
      sda_oe   <= 1'b0;
    end else begin
      case (state_ff)
        ST_RX: begin
          if (scl_rise) begin
            shift_ff   <= rx_byte; // [RL5]
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (bit_cnt_ff == 3'h7) begin
              ack_ff  <= nxt_ack;
              full_ff <= 1'b1;
              if (byte_no_ff == 3'h0) begin
                rw_ff <= sda_s;
              end
            end
          end else if (scl_fall && full_ff) begin
            state_ff <= ST_ACK;
            full_ff  <= 1'b0;
            sda_oe   <= ack_ff; // [RL6] [RL7] [RL8]
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            sda_oe     <= 1'b0;
            byte_no_ff <= (byte_no_ff == 3'h7) ? byte_no_ff : byte_no_ff + 3'h1;
            if (!ack_ff) begin
              state_ff <= ST_IDLE;
            end else if ((byte_no_ff == 3'h0) && rw_ff) begin
              state_ff   <= ST_TX;
              shift_ff   <= tx_byte;
              sda_oe     <= ~tx_byte[7]; // [RL5]
              bit_cnt_ff <= 3'h0;
            end else begin
              state_ff <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_ff == 3'h7) begin
              state_ff   <= ST_MACK;
              sda_oe     <= 1'b0;
              bit_cnt_ff <= 3'h0;
              rd_idx_ff  <= rd_idx_ff + 2'h1; // [RL16]
            end else begin
              shift_ff   <= {shift_ff[6:0], 1'b0};
              sda_oe     <= ~shift_ff[6];
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack_ff <= ~sda_s;
          end else if (scl_fall) begin
            if (mack_ff) begin
              state_ff <= ST_TX;
              shift_ff <= tx_byte;
              sda_oe   <= ~tx_byte[7];
            end else begin
              state_ff <= ST_IDLE;
            end
          end
        end
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        default: begin
          state_ff <= ST_IDLE;
          sda_oe   <= 1'b0;
        end
      endcase
    end
  end

  assign sda_o = 1'b0;

  // register pointer; a read never touches it
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      ptr_ff <= `PTR_TEMP; // [RL22]
    end else if (ptr_wr) begin
      ptr_ff <= rx_byte; // [RL2] [RL3]
    end
  end

  // trigger is armed by a pointer byte and lost if data follows
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      trig_pend_ff <= 1'b0;
    end else if (ptr_wr) begin
      trig_pend_ff <= (rx_byte <= `PTR_HUM) && (seq_ff == SEQ_SLEEP); // [RL12] [RL13]
    end else if (rx_end || trig_fire) begin
      trig_pend_ff <= 1'b0;
    end
  end

  // configuration; reset bit is never stored so it reads back zero
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      cfg_ff    <= `CFG_RESET & `CFG_WR_MASK; // [RL24]
      cfg_hi_ff <= 8'h00;
    end else if (wr_lo) begin
      cfg_ff <= {cfg_hi_ff, rx_byte} & `CFG_WR_MASK;
    end else if (wr_hi) begin
      cfg_hi_ff <= rx_byte;
    end
  end

  // power-up window; software reset does not reopen it
  always_ff @(posedge clk) begin
    if (rst) begin
      startup_ff   <= 1'b1;
      start_cnt_ff <= 21'h0;
    end else if (start_cnt_ff == 21'(STARTUP_CYC - 1)) begin
      startup_ff <= 1'b0; // [RL9]
    end else begin
      start_cnt_ff <= start_cnt_ff + 21'h1;
    end
  end

  // supply monitor sampled at the third edge after release, once the
  // synchroniser shows the pin rather than its own reset value, and at each trigger
  always_ff @(posedge clk) begin
    if (rst) begin
      por_ff      <= 2'h0;
      low_flag_ff <= 1'b0;
    end else begin
      por_ff <= (por_ff == 2'h3) ? por_ff : por_ff + 2'h1;
      if ((por_ff == 2'h2) || (trig_fire && !startup_ff)) begin
        low_flag_ff <= low_s; // [RL21]
      end
    end
  end

  // conversion length from the resolution selects
  always_comb begin
    temp_len = cfg_ff[`CFG_TEMP_RESOLUTION_SEL_BIT] ? 21'(TEMP11_CYC) : 21'(TEMP14_CYC); // [RL14]
    case (cfg_ff[`CFG_HUMIDITY_RESOLUTION_SEL_HI:`CFG_HUMIDITY_RESOLUTION_SEL_LO])
      `HUMIDITY_RESOLUTION_SEL_11: hum_len = 21'(HUM11_CYC); // [RL15]
      `HUMIDITY_RESOLUTION_SEL_8:  hum_len = 21'(HUM8_CYC); // [RL15]
      default:  hum_len = 21'(HUM14_CYC); // [RL15]
    endcase
  end

  // measurement sequencer and result registers
  always_ff @(posedge clk) begin
    if (rst || soft_rst) begin
      seq_ff   <= SEQ_SLEEP; // [RL11]
      cnt_ff   <= 21'h0;
      comb_ff  <= 1'b0;
      rdy_t_ff <= 1'b1;
      rdy_h_ff <= 1'b1;
      temp_ff  <= 14'h0;
      hum_ff   <= 14'h0;
    end else if (abort_req) begin
      seq_ff <= SEQ_SLEEP; // [RL19]
      cnt_ff <= 21'h0;
    end else begin
      case (seq_ff)
        SEQ_SLEEP: begin
          if (trig_fire && !startup_ff) begin
            cnt_ff  <= 21'h0;
            comb_ff <= combined;
            if ((ptr_ff == `PTR_HUM) && !combined) begin
              seq_ff   <= SEQ_CONV_H; // [RL13]
              rdy_h_ff <= 1'b0;
            end else begin
              seq_ff   <= SEQ_CONV_T; // [RL12] [RL13]
              rdy_t_ff <= 1'b0;
              rdy_h_ff <= combined ? 1'b0 : rdy_h_ff;
            end
          end
        end
        SEQ_CONV_T: begin
          if (cnt_ff >= temp_len - 21'h1) begin
            temp_ff  <= temp_code;
            rdy_t_ff <= 1'b1;
            cnt_ff   <= 21'h0;
            seq_ff   <= comb_ff ? SEQ_CONV_H : SEQ_SLEEP; // [RL12] [RL11]
          end else begin
            cnt_ff <= cnt_ff + 21'h1; // [RL18]
          end
        end
        SEQ_CONV_H: begin
          if (cnt_ff >= hum_len - 21'h1) begin
            hum_ff   <= hum_code;
            rdy_h_ff <= 1'b1;
            cnt_ff   <= 21'h0;
            seq_ff   <= SEQ_SLEEP; // [RL11]
          end else begin
            cnt_ff <= cnt_ff + 21'h1;
          end
        end
        default: begin
          seq_ff <= SEQ_SLEEP;
        end
      endcase
    end
  end

  // analog control follows the sequencer state
  assign meas_active = (seq_ff != SEQ_SLEEP);
  assign conv_temp   = (seq_ff == SEQ_CONV_T);
  assign conv_hum    = (seq_ff == SEQ_CONV_H);
  assign heater_on   = cfg_ff[`CFG_HEATER_ENABLE_BIT] && meas_active; // [RL20]

  property p_addr_mismatch;
    @(posedge clk) disable iff (rst)
      (rx_end && (byte_no_ff == 3'h0) && (rx_byte[7:1] != `I2C_SLAVE_ADDR)) |=> !ack_ff;
  endproperty
  a_addr_mismatch: assert property (p_addr_mismatch) else $error("foreign address acked"); // [RL8]

  property p_ptr_unused;
    @(posedge clk) disable iff (rst)
      (rx_end && (byte_no_ff == 3'h1) && !is_known(rx_byte)) |=> (!ack_ff && $stable(ptr_ff));
  endproperty
  a_ptr_unused: assert property (p_ptr_unused) else $error("unused pointer acked"); // [RL7]

  property p_ro_data_nack;
    @(posedge clk) disable iff (rst)
      (rx_end && (byte_no_ff >= 3'h2) && (ptr_ff != `PTR_CFG)) |=> !ack_ff;
  endproperty
  a_ro_data_nack: assert property (p_ro_data_nack) else $error("read-only write acked"); // [RL6]

  property p_not_ready_nack;
    @(posedge clk) disable iff (rst)
      (rx_end && (byte_no_ff == 3'h0) && rx_byte[0] && (ptr_ff == `PTR_HUM) && !rdy_h_ff)
        |=> !ack_ff;
  endproperty
  a_not_ready_nack: assert property (p_not_ready_nack) else $error("stale result acked"); // [RL17]

  property p_startup_sleep;
    @(posedge clk) disable iff (rst)
      startup_ff |-> (seq_ff == SEQ_SLEEP);
  endproperty
  a_startup_sleep: assert property (p_startup_sleep) else $error("conversion in power-up"); // [RL9]

  property p_abort;
    @(posedge clk) disable iff (rst)
      abort_req |=> ((seq_ff == SEQ_SLEEP) && !trig_pend_ff)[*2];
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted"); // [RL19]

  property p_trigger;
    @(posedge clk) disable iff (rst)
      (trig_fire && !startup_ff && (seq_ff == SEQ_SLEEP) && !soft_rst && !abort_req)
        |=> (seq_ff != SEQ_SLEEP) && $changed(seq_ff);
  endproperty
  a_trigger: assert property (p_trigger) else $error("trigger did not start"); // [RL11]

  property p_heater;
    @(posedge clk) disable iff (rst)
      (seq_ff == SEQ_SLEEP) |-> !heater_on;
  endproperty
  a_heater: assert property (p_heater) else $error("heater on in sleep"); // [RL20]

  property p_low_flag;
    @(posedge clk) disable iff (rst)
      (trig_fire && !startup_ff) |=> (low_flag_ff == $past(low_s));
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("supply flag not refreshed"); // [RL21]

  property p_soft_reset;
    @(posedge clk) disable iff (rst)
      soft_rst |=> ((ptr_ff == `PTR_TEMP) && (cfg_ff == `CFG_RESET) && !cfg_ff[`CFG_RST_BIT]);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset failed"); // [RL24]

endmodule

// file: dv/bus_master.sv
`timescale 1ns/1ns
module bus_master #(
  parameter int Q = 8
) (
  // system clock paces the bus
  input  wire logic clk,
  // bus lines; sda_in is the resolved wire
  input  wire logic sda_in,
  output logic      scl,
  output logic      sda
);
  // released lines sit high through the pull-up
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // start or repeated start: sda falls while scl is high
  task automatic start_c();
    sda = 1'b1;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    sda = 1'b0;
    hold(Q);
    scl = 1'b0;
    hold(Q);
  endtask

  // stop: sda rises while scl is high
  task automatic stop_c();
    sda = 1'b0;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    sda = 1'b1;
    hold(Q);
  endtask

  // one clock pulse, sda set while scl low, level taken mid high
  task automatic clock_bit(input logic b, output logic s);
    sda = b;
    hold(Q);
    scl = 1'b1;
    hold(Q);
    s = sda_in;
    hold(Q);
    scl = 1'b0;
    hold(Q);
  endtask

  // byte out msb first, then the slave's acknowledge
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
    clock_bit(1'b1, s);
    ack = ~s;
  endtask

  // byte in msb first; nack on the last byte ends the read
  task automatic get(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clock_bit(1'b1, s);
      d[i] = s;
    end
    clock_bit(last, s);
  endtask
endmodule

// file: dv/humidity_temp_i2c_measure_ctrl_tb.sv
`timescale 1ns/1ns
module humidity_temp_i2c_measure_ctrl_tb;
  localparam int STUP = 3000;
  localparam int T14 = 2000, T11 = 1200, H14 = 2200, H11 = 1400, H8 = 800;
  localparam logic [15:0] MFG = 16'hC3C3; // arbitrary value
  localparam logic [15:0] CF [5] = '{16'h0000, 16'h0400, 16'h0000, 16'h0100, 16'h0200};
  localparam int LN [5] = '{T14, T11, H14, H11, H8};

  logic        clk = 1'b0;
  logic        rst, scl, sda_m, sda_o, sda_oe, supply_low, heater_enable_exp;
  logic        meas_active, conv_temp, conv_hum, heater_on;
  logic [13:0] temp_code, hum_code;
  wire         sda_bus = sda_m & ~(sda_oe & ~sda_o);
  int          num_errors = 0, check_count = 0, t_cnt = 0, h_cnt = 0;

  always #5 clk = ~clk;

  hts_measure_ctrl #(.STARTUP_CYC(STUP), .TEMP14_CYC(T14), .TEMP11_CYC(T11),
    .HUM14_CYC(H14), .HUM11_CYC(H11), .HUM8_CYC(H8), .MFG_ID(MFG)) u_hts_measure_ctrl (
    .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_bus), .sda_o(sda_o), .sda_oe(sda_oe),
    .temp_code(temp_code), .hum_code(hum_code), .supply_low(supply_low),
    .meas_active(meas_active), .conv_temp(conv_temp), .conv_hum(conv_hum),
    .heater_on(heater_on));

  bus_master u_bus_master (.clk(clk), .sda_in(sda_bus), .scl(scl), .sda(sda_m));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // conversion lengths seen at the pins
  always @(posedge clk) begin
    if (conv_temp === 1'b1) t_cnt <= t_cnt + 1;
    if (conv_hum === 1'b1) h_cnt <= h_cnt + 1;
  end

  // heater follows measurement mode only when enabled
  always @(negedge clk) begin
    if (!rst) chk(heater_on, meas_active & heater_enable_exp, "heater");
  end

  // write: address, pointer, n data bytes; gives up at the first nack
  task automatic wr(input logic [7:0] p, input int n, input logic [15:0] d, output int na);
    logic       k;
    logic [7:0] b [4];
    b = '{8'h80, p, d[15:8], d[7:0]};
    na = 0;
    u_bus_master.start_c();
    for (int i = 0; i < n + 2; i++) begin
      u_bus_master.put(b[i], k);
      if (k !== 1'b1) break;
      na++;
    end
    u_bus_master.stop_c();
  endtask

  // read n bytes from the current pointer
  task automatic rd(input int n, output logic ak, output logic [31:0] d);
    logic [7:0] b;
    d = '0;
    u_bus_master.start_c();
    u_bus_master.put(8'h81, ak);
    if (ak === 1'b1) begin
      for (int i = 0; i < n; i++) begin
        u_bus_master.get(i == n - 1, b);
        d = {d[23:0], b};
      end
    end
    u_bus_master.stop_c();
  endtask

  // bounded wait for the sequencer to fall back asleep
  task automatic wait_idle();
    int n;
    n = 0;
    while (meas_active !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk(n < 5000, 1, "conversion end");
  endtask

  task automatic t_powerup();
    logic        k;
    logic [31:0] d;
    int          na;
    u_bus_master.start_c();
    u_bus_master.put(8'h92, k);
    u_bus_master.stop_c();
    chk(k, 0, "foreign address");
    rd(2, k, d);
    chk(k, 0, "result read in power-up");
    wr(8'h02, 2, 16'h1000, na);
    chk(na, 1, "config pointer in power-up");
    repeat (STUP) @(negedge clk);
    rd(2, k, d);
    chk({k, d[15:0]}, {1'b1, 16'h0000}, "pointer and result after reset");
    $display("done powerup");
  endtask

  task automatic t_regs();
    logic        k;
    logic [31:0] d;
    int          na;
    wr(8'h05, 0, 16'h0000, na);
    chk(na, 1, "reserved pointer");
    wr(8'hFE, 2, 16'h1234, na);
    chk(na, 2, "write to id");
    rd(2, k, d);
    chk({k, d[15:0]}, {1'b1, MFG}, "id word");
    wr(8'h02, 2, 16'h7F00, na);
    chk(na, 4, "config write");
    rd(2, k, d);
    chk({k, d[15:0]}, {1'b1, 16'h3F00}, "config readback");
    $display("done regs");
  endtask

  task automatic t_combined();
    logic        k;
    logic [31:0] d;
    int          na;
    heater_enable_exp = 1'b1;
    wr(8'h02, 2, 16'h3000, na);
    temp_code = 14'h1ABC;
    hum_code = 14'h0DEF;
    supply_low = 1'b0;
    t_cnt = 0;
    h_cnt = 0;
    wr(8'h00, 0, 16'h0000, na);
    rd(4, k, d);
    chk(k, 0, "read while converting");
    wait_idle();
    chk(t_cnt, T14, "temperature length");
    chk(h_cnt, H14, "humidity length");
    rd(4, k, d);
    chk({k, d}, {1'b1, temp_code, 2'b00, hum_code, 2'b00}, "combined result");
    wr(8'h02, 0, 16'h0000, na);
    rd(2, k, d);
    chk(d[15:0], 16'h3000, "supply flag refreshed");
    heater_enable_exp = 1'b0;
    $display("done combined");
  endtask

  task automatic t_single();
    logic        k;
    logic [31:0] d;
    logic [13:0] ex;
    int          na;
    for (int i = 0; i < 5; i++) begin
      wr(8'h02, 2, CF[i], na);
      temp_code = {10'h2A5, i[3:0]};
      hum_code = {10'h15A, i[3:0]};
      ex = (i < 2) ? temp_code : hum_code;
      t_cnt = 0;
      h_cnt = 0;
      wr((i < 2) ? 8'h00 : 8'h01, 0, 16'h0000, na);
      rd(2, k, d);
      chk(k, 0, "read before result");
      wait_idle();
      chk((i < 2) ? t_cnt : h_cnt, LN[i], "single length");
      chk((i < 2) ? h_cnt : t_cnt, 0, "no second conversion");
      rd(2, k, d);
      chk({k, d[15:0]}, {1'b1, ex, 2'b00}, "single result");
    end
    $display("done single");
  endtask

  task automatic t_abort();
    logic        k;
    logic [31:0] d;
    int          na;
    wr(8'h02, 2, 16'h0000, na);
    wr(8'h00, 0, 16'h0000, na);
    chk(meas_active, 1, "conversion started");
    wr(8'h00, 0, 16'h0000, na);
    chk(meas_active, 0, "conversion aborted");
    rd(2, k, d);
    chk(k, 0, "aborted result not ready");
    $display("done abort");
  endtask

  task automatic t_soft();
    logic        k;
    logic [31:0] d;
    int          na;
    wr(8'h02, 2, 16'h8000, na);
    chk(na, 4, "soft reset write");
    rd(2, k, d);
    chk({k, d[15:0]}, {1'b1, 16'h0000}, "pointer after soft reset");
    wr(8'h02, 0, 16'h0000, na);
    rd(2, k, d);
    chk(d[15:0], 16'h1000, "config after soft reset");
    $display("done soft reset");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // cut a hang short well past the expected run of about 47k cycles
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  // reset, then the scenarios in order
  initial begin
    rst = 1'b1;
    temp_code = 14'h0000;
    hum_code = 14'h0000;
    supply_low = 1'b1;
    heater_enable_exp = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    t_powerup();
    t_regs();
    t_combined();
    t_single();
    t_abort();
    t_soft();
    conclude();
  end
endmodule
